// [rtl/dct_defs.svh]
`ifndef DCT_DEFS_SVH
`define DCT_DEFS_SVH

// ****************************************
// Clock and bit timing
// ****************************************
`define DCT_CLK_MHZ          200
`define DCT_BIT_PERIOD_NS    1000
`define DCT_BIT_CYC          ((`DCT_BIT_PERIOD_NS * `DCT_CLK_MHZ) / 1000)
`define DCT_SHORT_NUM        1
`define DCT_LONG_NUM         4
`define DCT_DUTY_DEN         5
`define DCT_CNT_W            16

// ****************************************
// Pattern and frame
// ****************************************
`define DCT_PAT_W            16
`define DCT_LEN_W            5
`define DCT_PKT_BITS_RST     5'h08
`define DCT_PAT_RST          16'h0000

// ****************************************
// Register map (host side, Wishbone)
// ****************************************
`define DCT_ADR_W            4
`define DCT_REG_CTRL         4'h0
`define DCT_REG_PAT          4'h4
`define DCT_REG_STAT         4'h8
`define DCT_REG_MASK         4'hc
`define DCT_CTRL_SEND        0
`define DCT_CTRL_ENABLE      1
`define DCT_CTRL_LEN_LO      8
`define DCT_STAT_DONE        0
`define DCT_STAT_RXBIT       1
`define DCT_STAT_BUSY        8

`endif

// [rtl/dct_pkg.sv]
package dct_pkg;
    typedef enum logic [1:0] {
        DCT_IDLE = 2'b00,
        DCT_HIGH = 2'b01,
        DCT_LOW  = 2'b11,
        DCT_DONE = 2'b10
    } dct_state_t;
endpackage : dct_pkg

// [rtl/dct_link_if.sv]
`timescale 1ns/1ps
interface dct_link_if;
    logic wire_out;
    logic tx_enable;
    logic tx_done;
    modport tx (output wire_out, input tx_enable, output tx_done);
    modport rx (input wire_out, output tx_enable, input tx_done);
endinterface : dct_link_if

// [rtl/dct_rx_sampler.sv]
`timescale 1ns/1ps
`include "dct_defs.svh"
module dct_rx_sampler (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic line_in,
    output logic      bit_valid,
    output logic      bit_value
);
    typedef struct packed {
        logic [1:0]            sync;
        logic                  prev;
        logic                  armed;
        logic [`DCT_CNT_W-1:0] cnt;
        logic                  vld;
        logic                  val;
    } dct_smp_t;
    localparam logic [`DCT_CNT_W-1:0] HALF = `DCT_CNT_W'(`DCT_BIT_CYC / 2);
    dct_smp_t s_r, s_nxt;
    always_comb begin
        s_nxt       = s_r;
        s_nxt.sync  = {s_r.sync[0], line_in};
        s_nxt.prev  = s_r.sync[1];
        s_nxt.vld   = 1'b0;
        if (s_r.sync[1] && !s_r.prev) begin
            s_nxt.armed = 1'b1;
            s_nxt.cnt   = '0;
        end else if (s_r.armed) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
            if (s_r.cnt == HALF - 1'b1) begin
                // Sample at mid bit
                s_nxt.armed = 1'b0;
                s_nxt.vld   = 1'b1;
                s_nxt.val   = s_r.sync[1];
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) s_r <= '0;
        else s_r <= s_nxt;
    end
    assign bit_valid = s_r.vld;
    assign bit_value = s_r.val;
endmodule : dct_rx_sampler

// [rtl/dct_tx.sv]
`timescale 1ns/1ps
`include "dct_defs.svh"
module dct_tx (
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    dct_link_if.tx                     link,
    input  wire logic                  send,
    input  wire logic [`DCT_PAT_W-1:0] pattern,
    input  wire logic [`DCT_LEN_W-1:0] pkt_bits,
    output logic                       busy
);
    localparam logic [`DCT_CNT_W-1:0] PERIOD = `DCT_CNT_W'(`DCT_BIT_CYC);
    // Short rounds down, long rounds up, so the gap stays wide
    localparam logic [`DCT_CNT_W-1:0] SHORT =
        `DCT_CNT_W'((`DCT_BIT_CYC * `DCT_SHORT_NUM) / `DCT_DUTY_DEN);
    localparam logic [`DCT_CNT_W-1:0] LONG =
        `DCT_CNT_W'((`DCT_BIT_CYC * `DCT_LONG_NUM + `DCT_DUTY_DEN - 1) / `DCT_DUTY_DEN);

    typedef struct packed {
        dct_pkg::dct_state_t   st;
        logic                  send_d;
        logic [`DCT_PAT_W-1:0] shreg;
        logic [`DCT_LEN_W-1:0] oneshot_a;
        logic [`DCT_LEN_W-1:0] oneshot_b;
        logic [`DCT_CNT_W-1:0] period_cnt;
        logic                  wire_q;
        logic                  done;
    } dct_tx_st_t;
    dct_tx_st_t s_r, s_nxt;
    logic       short_on;
    logic       long_on;

    // ****************************************
    // Duty timers and combiner
    // ****************************************
    // One ahead: the line is registered, else each pulse grows a cycle
    assign short_on = (s_r.period_cnt < SHORT - 1'b1);
    assign long_on  = (s_r.period_cnt < LONG - 1'b1);

    always_comb begin
        s_nxt        = s_r;
        s_nxt.send_d = send;
        s_nxt.done   = 1'b0;
        s_nxt.wire_q = 1'b0;
        case (s_r.st)
            dct_pkg::DCT_IDLE: begin
                // Launch on send edge while enabled
                if (send && !s_r.send_d && link.tx_enable && pkt_bits != '0) begin
                    s_nxt.st         = dct_pkg::DCT_HIGH;
                    s_nxt.shreg      = pattern << (`DCT_PAT_W - pkt_bits);
                    s_nxt.oneshot_a  = pkt_bits - 1'b1;
                    s_nxt.oneshot_b  = pkt_bits - 5'h02;
                    s_nxt.period_cnt = '0;
                end
            end
            dct_pkg::DCT_HIGH, dct_pkg::DCT_LOW: begin
                // Bit value only shapes the high time
                s_nxt.wire_q = s_r.shreg[`DCT_PAT_W-1] ? long_on : short_on;
                s_nxt.st = s_nxt.wire_q ? dct_pkg::DCT_HIGH : dct_pkg::DCT_LOW;
                if (s_r.period_cnt == PERIOD - 1'b1) begin
                    s_nxt.period_cnt = '0;
                    s_nxt.shreg      = s_r.shreg << 1;
                    if (s_r.oneshot_a == '0) begin
                        s_nxt.st     = dct_pkg::DCT_DONE;
                        s_nxt.wire_q = 1'b0;
                    end else begin
                        s_nxt.oneshot_a = s_r.oneshot_a - 1'b1;
                        s_nxt.oneshot_b = s_r.oneshot_b - 1'b1;
                        s_nxt.st        = dct_pkg::DCT_HIGH;
                        s_nxt.wire_q    = 1'b1;
                    end
                end else begin
                    s_nxt.period_cnt = s_r.period_cnt + 1'b1;
                end
            end
            dct_pkg::DCT_DONE: begin
                s_nxt.done = 1'b1;
                s_nxt.st   = dct_pkg::DCT_IDLE;
            end
            default: s_nxt.st = dct_pkg::DCT_IDLE;
        endcase
        // First bit starts high on launch
        if (s_r.st == dct_pkg::DCT_IDLE && s_nxt.st == dct_pkg::DCT_HIGH) begin
            s_nxt.wire_q = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.wire_out = s_r.wire_q;
    assign link.tx_done  = s_r.done;
    assign busy          = (s_r.st != dct_pkg::DCT_IDLE);
endmodule : dct_tx

// [rtl/dct_host.sv]
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "dct_defs.svh"
module dct_host (
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    dct_link_if.rx                      link,
    input  wire logic                   tx_busy,
    output logic                        send,
    output logic [`DCT_PAT_W-1:0]       pattern,
    output logic [`DCT_LEN_W-1:0]       pkt_bits,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [`DCT_ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic [31:0]                 wb_dat_o,
    output logic                        wb_ack_o,
    output logic                        irq,
    output logic                        rx_valid,
    output logic [7:0]                  rx_byte
);
    typedef struct packed {
        logic                  en;
        logic                  send;
        logic [`DCT_PAT_W-1:0] pat;
        logic [`DCT_LEN_W-1:0] len;
        logic [1:0]            stat;
        logic [1:0]            mask;
        logic                  ack;
        logic [31:0]           dat;
        logic [1:0]            done_sync;
        logic [7:0]            rx;
        logic [3:0]            rx_cnt;
        logic                  rx_vld;
    } dct_host_st_t;
    dct_host_st_t s_r, s_nxt;
    logic         bit_valid;
    logic         bit_value;
    logic         acc;
    logic         wr;
    logic [1:0]   ev;

    dct_rx_sampler u_smp (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .line_in   (link.wire_out),
        .bit_valid (bit_valid),
        .bit_value (bit_value)
    );

    assign acc = wb_cyc_i && wb_stb_i && !s_r.ack;
    assign wr  = acc && wb_we_i;

    always_comb begin
        s_nxt           = s_r;
        s_nxt.ack       = acc;
        s_nxt.send      = 1'b0;
        s_nxt.rx_vld    = 1'b0;
        s_nxt.done_sync = {s_r.done_sync[0], link.tx_done};
        ev              = {1'b0, s_r.done_sync[1]};
        if (bit_valid) begin
            s_nxt.rx = {s_r.rx[6:0], bit_value};
            if (s_r.rx_cnt == 4'h7) begin
                s_nxt.rx_cnt = '0;
                s_nxt.rx_vld = 1'b1;
                ev[1]        = 1'b1;
            end else begin
                s_nxt.rx_cnt = s_r.rx_cnt + 1'b1;
            end
        end
        s_nxt.dat = 32'h0000_0000;
        case (wb_adr_i)
            `DCT_REG_CTRL: s_nxt.dat = {19'h0, s_r.len, 6'h0, s_r.en, 1'b0};
            `DCT_REG_PAT:  s_nxt.dat = {16'h0, s_r.pat};
            `DCT_REG_STAT: s_nxt.dat = {23'h0, tx_busy, 6'h0, s_r.stat};
            `DCT_REG_MASK: s_nxt.dat = {30'h0, s_r.mask};
            default:       s_nxt.dat = 32'h0000_0000;
        endcase
        if (wr) begin
            case (wb_adr_i)
                `DCT_REG_CTRL: begin
                    s_nxt.en   = wb_dat_i[`DCT_CTRL_ENABLE];
                    s_nxt.send = wb_dat_i[`DCT_CTRL_SEND];
                    s_nxt.len  = wb_dat_i[`DCT_CTRL_LEN_LO +: `DCT_LEN_W];
                end
                // Pattern locked while a frame runs
                `DCT_REG_PAT: if (!tx_busy) s_nxt.pat = wb_dat_i[`DCT_PAT_W-1:0];
                `DCT_REG_STAT: s_nxt.stat = s_r.stat & ~wb_dat_i[1:0];
                `DCT_REG_MASK: s_nxt.mask = wb_dat_i[1:0];
                default: ;
            endcase
        end
        s_nxt.stat = s_nxt.stat | ev;  // Set wins over clear
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_r     <= '0;
            s_r.len <= `DCT_PKT_BITS_RST;
            s_r.pat <= `DCT_PAT_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.tx_enable = s_r.en;
    assign send           = s_r.send;
    assign pattern        = s_r.pat;
    assign pkt_bits       = s_r.len;
    assign wb_ack_o       = s_r.ack;
    assign wb_dat_o       = s_r.dat;
    assign irq            = |(s_r.stat & s_r.mask);
    assign rx_valid       = s_r.rx_vld;
    assign rx_byte        = s_r.rx;
endmodule : dct_host

// [bench/dct_link_chk.sv]
`timescale 1ns/1ps
module dct_link_chk (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wire_out,
    input wire logic tx_enable,
    input wire logic tx_done
);
    logic [15:0] hi_r;
    logic [15:0] per_r;
    logic        wd_r;
    logic        fr_r;

    // ****************
    // Pulse timing
    // ****************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hi_r  <= 16'h0;
            per_r <= 16'h0;
            wd_r  <= 1'b0;
            fr_r  <= 1'b0;
        end else begin
            hi_r  <= wire_out ? hi_r + 16'h1 : 16'h0;
            per_r <= (wire_out && !wd_r) ? 16'h1 : per_r + 16'h1;
            wd_r  <= wire_out;
            fr_r  <= tx_done ? 1'b0 : (wire_out ? 1'b1 : fr_r);
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    pulse_width_a: assert property (
        $fell(wire_out) |-> hi_r == 16'h0028 || hi_r == 16'h00a0) else $error("bad pulse width");
    bit_period_a: assert property (
        $rose(wire_out) && fr_r |-> per_r == 16'h00c8) else $error("bad bit period");
    start_enable_a: assert property (
        $rose(wire_out) && !fr_r |-> tx_enable) else $error("frame without enable");
    high_bound_a: assert property (
        wire_out |-> hi_r < 16'h00a0) else $error("pulse too long");
    done_pulse_a: assert property (
        tx_done |=> !tx_done) else $error("done pulse too long");
    done_low_a: assert property (
        tx_done |-> !wire_out ##1 !wire_out) else $error("line high at frame end");
    done_frame_a: assert property (
        tx_done |-> fr_r && per_r >= 16'h00c8 && per_r <= 16'h00ca) else $error("early done");
    reset_idle_a: assert property (
        $fell(sys_rst) |-> !wire_out && !tx_done) else $error("line active after reset");

    cover property ($fell(wire_out) && hi_r == 16'h00a0);
    cover property ($fell(wire_out) && hi_r == 16'h0028);
    cover property (tx_done);
endmodule : dct_link_chk

// [bench/tb_duty_cycle_serial_transmitter.sv]
`timescale 1ns/1ps
`include "dct_defs.svh"
module tb_duty_cycle_serial_transmitter;
    logic        sys_clk  = 1'b0;
    logic        sys_rst  = 1'b1;
    logic        cyc      = 1'b0;
    logic        stb      = 1'b0;
    logic        we       = 1'b0;
    logic [3:0]  adr      = 4'h0;
    logic [31:0] wdat     = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack;
    logic        irq;
    logic        rx_valid;
    logic [7:0]  rx_byte;
    logic [7:0]  rx_last  = 8'h00;
    logic [7:0]  rx_acc   = 8'h00;
    logic [7:0]  rx_exp   = 8'h00;
    int          rx_bits  = 0;
    logic        send;
    logic [15:0] pattern;
    logic [4:0]  pkt_bits;
    logic        busy;
    logic [31:0] seed     = 32'hed69;
    int          cnt      = 0;
    int          failures = 0;
    int          compares = 0;

    dct_link_if link ();
    dct_tx i_dct_tx (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link), .send(send),
        .pattern(pattern), .pkt_bits(pkt_bits), .busy(busy));
    dct_host i_dct_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link), .tx_busy(busy),
        .send(send), .pattern(pattern), .pkt_bits(pkt_bits), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq(irq), .rx_valid(rx_valid), .rx_byte(rx_byte));
    dct_link_chk i_dct_link_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .wire_out(link.wire_out), .tx_enable(link.tx_enable), .tx_done(link.tx_done));

    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cnt <= cnt + 1;
    always @(posedge sys_clk) if (rx_valid === 1'b1) rx_last <= rx_byte;

    // ****************
    // Helpers
    // ****************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
    endfunction : lfsr

    function automatic int exp_high(input logic b);
        if (b) return (`DCT_BIT_CYC * `DCT_LONG_NUM) / `DCT_DUTY_DEN;
        return (`DCT_BIT_CYC * `DCT_SHORT_NUM) / `DCT_DUTY_DEN;
    endfunction : exp_high

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge sys_clk);
        while (ack !== 1'b1) @(posedge sys_clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic wait_lvl(input logic v, input int lim);
        int n;
        n = 0;
        while (link.wire_out !== v && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : wait_lvl

    // Checks every slot, then that nothing repeats and status follows
    task automatic frame(input logic [15:0] p, input int n, input logic m);
        int   h;
        int   tp;
        logic got;
        tp  = 0;
        got = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            wait_lvl(1'b1, 500);
            if (i < n - 1) chk("period", cnt - tp, `DCT_BIT_CYC);
            tp = cnt;
            h = 0;
            while (link.wire_out === 1'b1 && h < 300) begin
                @(posedge sys_clk);
                h++;
            end
            chk("high", h, exp_high(p[i]));
            // Receiver model: eight bits make a byte, count carries over frames
            rx_acc = {rx_acc[6:0], p[i]};
            rx_bits++;
            if (rx_bits == 8) begin
                rx_bits = 0;
                rx_exp  = rx_acc;
                got     = 1'b1;
            end
            if (i == n - 1) begin
                bus(1'b0, `DCT_REG_STAT, 32'h0);
                chk("busy", q[8], 1'b1);
                bus(1'b1, `DCT_REG_PAT, {16'h0, ~p});
                bus(1'b1, `DCT_REG_CTRL, (n << 8) | 32'h3);
            end
        end
        h = 0;
        while (link.tx_done !== 1'b1 && h < 400) begin
            @(posedge sys_clk);
            h++;
        end
        chk("done", link.tx_done, 1'b1);
        wait_lvl(1'b1, 300);
        chk("once", link.wire_out, 1'b0);
        chk("irq", irq, m);
        bus(1'b0, `DCT_REG_STAT, 32'h0);
        chk("stat", q[0], 1'b1);
        chk("rx_stat", q[1], got);
        chk("idle_busy", q[8], 1'b0);
        if (got) chk("rx", rx_last, rx_exp);
        bus(1'b0, `DCT_REG_PAT, 32'h0);
        chk("pat_kept", q, {16'h0, p});
        bus(1'b1, `DCT_REG_STAT, 32'h3);
        bus(1'b0, `DCT_REG_STAT, 32'h0);
        chk("stat_clr", q[1:0], 2'b00);
        chk("irq_clr", irq, 1'b0);
    endtask : frame

    // ****************
    // Sequence
    // ****************
    initial begin
        int n;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        bus(1'b0, `DCT_REG_PAT, 32'h0);
        chk("pat_rst", q, 32'h0);
        bus(1'b0, `DCT_REG_CTRL, 32'h0);
        chk("len_rst", q[12:8], 5'h08);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", q, 32'h0);
        chk("idle", link.wire_out, 1'b0);
        bus(1'b1, `DCT_REG_CTRL, 32'h0801);
        wait_lvl(1'b1, 300);
        chk("no_enable", link.wire_out, 1'b0);
        $display("register and enable test done");
        for (int k = 0; k < 5; k++) begin
            seed = lfsr(seed);
            n = (k == 0) ? 8 : (k == 1) ? 1 : (k == 2) ? 16 : int'(seed[19:16]) + 1;
            bus(1'b1, `DCT_REG_MASK, {31'h0, ~k[0]});
            bus(1'b1, `DCT_REG_PAT, {16'h0, seed[15:0]});
            bus(1'b1, `DCT_REG_CTRL, (n << 8) | 32'h3);
            frame(seed[15:0], n, ~k[0]);
            $display("frame test %0d of %0d bits done", k, n);
        end
        conclude();
    end

    initial begin
        repeat (40000) @(posedge sys_clk);
        failures++;
        conclude();
    end
endmodule : tb_duty_cycle_serial_transmitter
